// ===== fault_summary_defines.svh
/*
 * offsets, bit positions, masks and reset values of the fault summary register.
 * assumes inclusion by bare name from the design file, the host model and the bench.
 */
`ifndef FAULT_SUMMARY_DEFINES_SVH
`define FAULT_SUMMARY_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FSR_ADDR 9'h080
`define FSR_RESET 16'h0000
`define FSR_ALL_ONES 16'hffff
`define FSR_ZERO 16'h0000

// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define BIT_MEMQ 0
`define BIT_RSVD 1
`define BIT_CLKSRC 2
`define BIT_TIMEOUT 3
`define BIT_HEAT 4
`define BIT_CELLHI 5
`define BIT_CELLLO 6
`define BIT_OPEN 7
`define BIT_STACK 8
`define BIT_GND 9
`define BIT_CSUM 10
`define BIT_REFV 11
`define BIT_REGUL 12
`define BIT_TSEL 13
`define BIT_CSEL 14
`define BIT_DIEWARN 15

// flags that the host may set or clear here; bit 1 is reserved and the rest mirror detail registers
`define FSR_WRITABLE 16'hfb0c
`define FSR_TIMEOUT_CLR 16'h0008
`define FSR_REGUL_CLR 16'h1000
`define FSR_CSEL_CLR 16'h4000

`endif

// ===== fault_summary_pkg.sv
/*
 * types carried between the fault summary register and its neighbours.
 * uses none of the defines header's macros and does not include it.
 */
package fault_summary_pkg;

	// ----------------------------------------------------------------
	// detail register summaries, held in other blocks
	// ----------------------------------------------------------------
	typedef struct packed {
		logic open_connection_flag;
		logic cell_high_limit_flag;
		logic cell_low_limit_flag;
		logic [3:0] ext_sensor_heat_flag;
		logic [1:0] gpio_heat_flag;
		logic die_heat_flag;
		logic page_one_parity_flag;
		logic nvm_parity_flag;
		logic memory_queue_error_flag;
	} detail_flags_t;

	// ----------------------------------------------------------------
	// decoded command from the host interface
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic overwrite_prefix;
		logic [8:0] addr;
		logic [15:0] data;
	} host_cmd_t;

	typedef enum logic [1:0] {
		OVR_IDLE = 2'b01,
		OVR_ARMED = 2'b10
	} ovr_state_t;

endpackage

// ===== fault_summary_register.sv
/*
 * fault summary status register with active-low alarm output.
 * assumes commands arrive decoded, one cycle each, synchronous to clk.
 */
`timescale 1ns/1ps
`include "fault_summary_defines.svh"

module fault_summary_register (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire fault_summary_pkg::host_cmd_t cmd,
	input wire fault_summary_pkg::detail_flags_t detail,
	input wire logic [15:0] fault_set,
	output logic [15:0] rd_data_q,
	output logic [15:0] status_q,
	output logic fault_alarm_n
);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	fault_summary_pkg::ovr_state_t ovr_q;
	fault_summary_pkg::ovr_state_t ovr_d;
	logic [15:0] status_d;
	wire hit = cmd.addr == `FSR_ADDR;
	wire wr_hit = cmd.wr && hit;
	wire direct_wr = wr_hit && (ovr_q == fault_summary_pkg::OVR_ARMED);
	wire clear_wr = wr_hit && !direct_wr;
	wire [15:0] wmask = `FSR_WRITABLE;
	// hardware sets only reach writable positions; mirrors come from detail
	wire [15:0] hw_set = fault_set & wmask;

	// mirrored flags are rebuilt from detail every cycle, never from the host
	wire heat_any = |detail.ext_sensor_heat_flag | |detail.gpio_heat_flag | detail.die_heat_flag;
	wire csum_any = detail.page_one_parity_flag | detail.nvm_parity_flag;
	logic [15:0] mirror;
	always_comb begin
		mirror = `FSR_ZERO;
		mirror[`BIT_OPEN] = detail.open_connection_flag;
		mirror[`BIT_CELLHI] = detail.cell_high_limit_flag;
		mirror[`BIT_CELLLO] = detail.cell_low_limit_flag;
		mirror[`BIT_HEAT] = heat_any;
		mirror[`BIT_CSUM] = csum_any;
		mirror[`BIT_MEMQ] = detail.memory_queue_error_flag;
	end

	// writable part: overwrite, write-one-to-clear, or hold; detection ORed last
	wire [15:0] wr_kept = direct_wr ? (cmd.data & wmask) :
		clear_wr ? (status_q & ~cmd.data & wmask) :
		(status_q & wmask);
	// set wins over a clear in the same cycle
	assign status_d = mirror | wr_kept | hw_set;

	// ----------------------------------------------------------------
	// overwrite prefix tracking
	// ----------------------------------------------------------------
	// prefix arms until the next write to this register, which consumes it
	always_comb begin
		case (ovr_q)
			fault_summary_pkg::OVR_IDLE: ovr_d = cmd.overwrite_prefix ? fault_summary_pkg::OVR_ARMED
				: fault_summary_pkg::OVR_IDLE;
			fault_summary_pkg::OVR_ARMED: ovr_d = wr_hit ? fault_summary_pkg::OVR_IDLE
				: fault_summary_pkg::OVR_ARMED;
			default: ovr_d = fault_summary_pkg::OVR_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= `FSR_RESET;
			ovr_q <= fault_summary_pkg::OVR_IDLE;
		end else if (ce) begin
			status_q <= status_d;
			ovr_q <= ovr_d;
		end
	end

	// read data captured on a read hit, zero on other addresses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= `FSR_ZERO;
		end else if (ce && cmd.rd) begin
			rd_data_q <= hit ? status_q : `FSR_ZERO;
		end
	end

	// nor of all bits: any set flag is a fault
	assign fault_alarm_n = ~|status_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_prefix;
		ce && cmd.overwrite_prefix && !cmd.wr;
	endsequence
	// the write that consumes an armed prefix, with no detection to blur the result
	sequence s_direct_wr;
		ce && direct_wr && fault_set == `FSR_ZERO;
	endsequence
	sequence s_read_hit;
		ce && cmd.rd && hit;
	endsequence
	sequence s_read_miss;
		ce && cmd.rd && !hit;
	endsequence

	property p_alarm;
		@(posedge clk) disable iff (rst) (fault_alarm_n == 1'b0) == (status_q != `FSR_ZERO);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm does not match register");

	property p_all_ones;
		@(posedge clk) disable iff (rst) (ce && clear_wr && cmd.data == `FSR_ALL_ONES && fault_set == `FSR_ZERO)
			|=> ((status_q & wmask) == `FSR_ZERO);
	endproperty
	a_all_ones: assert property (p_all_ones) else $error("all-ones write left a flag");

	// the prefix may lead the write by a few cycles; a longer gap is legal but left unchecked here
	property p_overwrite;
		@(posedge clk) disable iff (rst) s_prefix ##[1:4] s_direct_wr
			|=> ((status_q & wmask) == ($past(cmd.data) & wmask));
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite not applied");

	property p_mirror;
		@(posedge clk) disable iff (rst) ce |=> ((status_q & ~wmask) == $past(mirror));
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirrored flag diverged");

	property p_timeout_clr;
		@(posedge clk) disable iff (rst) (ce && clear_wr && cmd.data == `FSR_TIMEOUT_CLR && !fault_set[`BIT_TIMEOUT])
			|=> !status_q[`BIT_TIMEOUT] && (status_q[`BIT_REGUL] == $past(status_q[`BIT_REGUL]) || $past(fault_set[`BIT_REGUL]));
	endproperty
	a_timeout_clr: assert property (p_timeout_clr) else $error("timeout clear wrong");

	property p_timeout_set;
		@(posedge clk) disable iff (rst) (ce && direct_wr && cmd.data[`BIT_TIMEOUT]) |=> status_q[`BIT_TIMEOUT] && !fault_alarm_n;
	endproperty
	a_timeout_set: assert property (p_timeout_set) else $error("overwrite did not set timeout");

	property p_heat;
		@(posedge clk) disable iff (rst) ce |=> status_q[`BIT_HEAT] == $past(heat_any);
	endproperty
	a_heat: assert property (p_heat) else $error("heat flag not following detail");

	property p_csum;
		@(posedge clk) disable iff (rst) ce |=> status_q[`BIT_CSUM] == $past(csum_any);
	endproperty
	a_csum: assert property (p_csum) else $error("checksum flag wrong");

	property p_regul;
		@(posedge clk) disable iff (rst) (ce && clear_wr && cmd.data == `FSR_REGUL_CLR && !fault_set[`BIT_REGUL])
			|=> !status_q[`BIT_REGUL];
	endproperty
	a_regul: assert property (p_regul) else $error("regulator flag not cleared");

	property p_csel;
		@(posedge clk) disable iff (rst) (ce && clear_wr && cmd.data == `FSR_CSEL_CLR && !fault_set[`BIT_CSEL])
			|=> !status_q[`BIT_CSEL];
	endproperty
	a_csel: assert property (p_csel) else $error("cell selector flag not cleared");

	property p_set_wins;
		@(posedge clk) disable iff (rst) (ce && wr_hit && fault_set[`BIT_TIMEOUT]) |=> status_q[`BIT_TIMEOUT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("detection lost to clear");

	property p_reset;
		@(posedge clk) $fell(rst) |-> status_q == `FSR_RESET && fault_alarm_n;
	endproperty
	a_reset: assert property (p_reset) else $error("register not zero after reset");

	property p_ce_hold;
		@(posedge clk) disable iff (rst) !ce |=> $stable(status_q);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with ce low");

	property p_rd_hit;
		@(posedge clk) disable iff (rst) s_read_hit |=> rd_data_q == $past(status_q);
	endproperty
	a_rd_hit: assert property (p_rd_hit) else $error("read data not the register");

	// other addresses belong to other registers; this one answers zero there
	property p_rd_miss;
		@(posedge clk) disable iff (rst) s_read_miss |=> rd_data_q == `FSR_ZERO;
	endproperty
	a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");

	property p_wr_miss;
		@(posedge clk) disable iff (rst) (ce && cmd.wr && !hit && fault_set == `FSR_ZERO)
			|=> (status_q & wmask) == ($past(status_q) & wmask);
	endproperty
	a_wr_miss: assert property (p_wr_miss) else $error("unmapped write changed a flag");

	property p_prefix_arm;
		@(posedge clk) disable iff (rst) (ce && cmd.overwrite_prefix && !wr_hit)
			|=> ovr_q == fault_summary_pkg::OVR_ARMED;
	endproperty
	a_prefix_arm: assert property (p_prefix_arm) else $error("prefix did not arm");

	// bit 1 has no flag behind it and must never read back as one
	property p_reserved;
		@(posedge clk) disable iff (rst) !status_q[`BIT_RSVD];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_ovr_legal;
		@(posedge clk) disable iff (rst) ovr_q == fault_summary_pkg::OVR_IDLE
			|| ovr_q == fault_summary_pkg::OVR_ARMED;
	endproperty
	a_ovr_legal: assert property (p_ovr_legal) else $error("prefix state not one-hot");

endmodule

// ===== fault_summary_host.sv
/* host model: drives decoded commands into the fault summary register.
 * assumes one caller at a time, entering just after a rising clk edge. */
`timescale 1ns/1ps
`include "fault_summary_defines.svh"
module fault_summary_host (
	input wire logic clk,
	output fault_summary_pkg::host_cmd_t cmd
);
	// ----------------------------------------
	// command tasks
	// ----------------------------------------
	initial cmd = '0;
	// a command stands up to its taking edge; the caller releases it with idle or a next command
	task automatic issue(input logic w, input logic r, input logic p, input logic [8:0] a, input logic [15:0] d);
		cmd <= '{w, r, p, a, d};
		@(posedge clk);
	endtask
	task automatic idle();
		cmd <= '0;
		@(posedge clk);
	endtask
	// clear by overwrite: prefix, then a zero write
	task automatic wipe();
		issue(1'b0, 1'b0, 1'b1, `FSR_ADDR, 16'h0000);
		issue(1'b1, 1'b0, 1'b0, `FSR_ADDR, `FSR_ZERO);
	endtask
endmodule

// ===== fault_summary_register_test.sv
/* self-checking bench: a row table of writes, then hand-written cases.
 * assumes a 50 MHz clk and the host model issuing every command. */
`timescale 1ns/1ps
`include "fault_summary_defines.svh"
module fault_summary_register_test;
	typedef struct {logic [15:0] set; logic ovr; logic [15:0] data; logic [15:0] exp;} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	fault_summary_pkg::host_cmd_t cmd;
	fault_summary_pkg::detail_flags_t detail = '0;
	logic [15:0] fault_set = '0;
	logic [15:0] rd_data_q;
	logic [15:0] status_q;
	logic fault_alarm_n;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	// status bit fed by each detail bit, lowest struct bit first
	int mir[13] = '{0, 10, 10, 4, 4, 4, 4, 4, 4, 4, 6, 5, 7};
	// rows chain: each starts from the previous expected register
	row_t rows[10] = '{'{16'h0008, 0, 16'h0000, 16'h0008}, '{16'h1000, 0, 16'h0008, 16'h1000},
		'{16'h4000, 0, 16'h1000, 16'h4000}, '{16'h0000, 0, 16'h4000, 16'h0000},
		'{16'hfb0c, 0, 16'hffff, 16'h0000}, '{16'h0000, 1, 16'h0008, 16'h0008},
		'{16'h0000, 1, 16'hffff, 16'hfb0c}, '{16'h0000, 0, 16'h0304, 16'hf808},
		'{16'h0000, 1, 16'h1000, 16'h1000}, '{16'h0000, 1, 16'h0000, 16'h0000}};

	fault_summary_register fault_summary_register_inst (.clk(clk), .rst(rst), .ce(ce), .cmd(cmd),
		.detail(detail), .fault_set(fault_set), .rd_data_q(rd_data_q), .status_q(status_q),
		.fault_alarm_n(fault_alarm_n));
	fault_summary_host fault_summary_host_inst (.clk(clk), .cmd(cmd));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// sampled 1 ns late so the edge's updates have landed, then back on an edge
	task automatic expect_status(input logic [15:0] exp);
		#1;
		check("status_q", status_q, exp); // register view
		check("fault_alarm_n", {15'h0, fault_alarm_n}, {15'h0, ~|exp}); // nor of all bits
		@(posedge clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	// the whole run needs some 180 cycles; a hang is cut well past that
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			close_out();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		check("rd_data_q", rd_data_q, 16'h0000);
		expect_status(16'h0000);
		// hardware set, optional prefix, one write, then the expected register
		foreach (rows[i]) begin
			fault_set <= rows[i].set;
			@(posedge clk);
			fault_set <= '0;
			fault_summary_host_inst.issue(1'b0, 1'b0, rows[i].ovr, `FSR_ADDR, 16'h0000);
			fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, `FSR_ADDR, rows[i].data);
			fault_summary_host_inst.idle();
			expect_status(rows[i].exp);
		end
		// each mirror survives overwrite and all-ones, and drops with its detail bit
		for (int i = 0; i < 13; i++) begin
			detail <= fault_summary_pkg::detail_flags_t'(13'h1 << i);
			fault_summary_host_inst.wipe();
			fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, `FSR_ADDR, `FSR_ALL_ONES);
			fault_summary_host_inst.idle();
			expect_status(16'h0001 << mir[i]);
			detail <= '0;
			repeat (2) @(posedge clk);
			expect_status(16'h0000);
		end
		// detection and clear in one cycle: the detection stays
		fault_set <= 16'h0008;
		fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, `FSR_ADDR, `FSR_TIMEOUT_CLR);
		fault_set <= '0;
		fault_summary_host_inst.idle();
		expect_status(16'h0008);
		// unmapped write ignored, mapped read gives the register, unmapped read gives zero
		fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, 9'h081, `FSR_ALL_ONES);
		fault_summary_host_inst.issue(1'b0, 1'b1, 1'b0, `FSR_ADDR, 16'h0000);
		fault_summary_host_inst.idle();
		check("rd_data_q", rd_data_q, 16'h0008);
		fault_summary_host_inst.issue(1'b0, 1'b1, 1'b0, 9'h081, 16'h0000);
		fault_summary_host_inst.idle();
		check("rd_data_q", rd_data_q, 16'h0000);
		// a low clock enable takes no write
		ce <= 1'b0;
		fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, `FSR_ADDR, `FSR_ALL_ONES);
		ce <= 1'b1;
		fault_summary_host_inst.idle();
		expect_status(16'h0008);
		// an unmapped write leaves an armed prefix for the next write here
		fault_summary_host_inst.issue(1'b0, 1'b0, 1'b1, `FSR_ADDR, 16'h0000);
		fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, 9'h081, 16'h0000);
		fault_summary_host_inst.issue(1'b1, 1'b0, 1'b0, `FSR_ADDR, 16'h0004);
		fault_summary_host_inst.idle();
		expect_status(16'h0004);
		// reset in mid-run empties the register
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		expect_status(16'h0000);
		close_out();
	end
endmodule
